// ===== core/amc_host_ctrl.sv
// Host controller that sets the converter's modes over its serial port.
`timescale 1ns/1ps
module amc_host_ctrl import amc_pkg::*; (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [2:0] CMD_OP,
  input wire logic [7:0] CMD_ADDR,
  input wire logic [15:0] CMD_WDATA,
  output logic CMD_ERROR,
  output logic RSP_VALID,
  output logic [31:0] RSP_DATA,
  output logic SCLK,
  output logic CS_N,
  output logic MOSI,
  input wire logic MISO,
  input wire logic AUX_PIN_ONE,
  input wire logic STREAM_BIT_CLOCK,
  input wire logic STREAM_TWO_SLOTS,
  output logic STREAM_VALID,
  output logic [23:0] STREAM_DATA,
  output logic [7:0] STREAM_STATUS,
  output logic [31:0] STREAM_CHECK,
  output logic [15:0] CTRL_SHADOW,
  output logic [15:0] STANDBY_SHADOW,
  output logic [15:0] SWITCH_SHADOW
);

  typedef struct packed {
    amc_state_type st;
    amc_op_type op;
    logic [2:0] ph;
    logic sclk;
    logic csn;
    logic mosi;
    logic [7:0] cnt;
    logic [7:0] nbits;
    logic [23:0] tx;
    logic [31:0] rx;
    logic [15:0] ctrl;
    logic [15:0] stby;
    logic [15:0] lsw;
    logic rsp_valid;
    logic [31:0] rsp_data;
    logic err;
    logic [2:0] miso_s;
    logic miso_lvl;
    logic [2:0] rdy_s;
    logic rdy_lvl;
    logic [2:0] tog_s;
    logic str_valid;
    logic [23:0] str_data;
    logic [7:0] str_stat;
    logic [31:0] str_check;
  } amc_host_state_type;

  amc_host_state_type state_reg;
  amc_host_state_type state_next;

  logic [63:0] rx_word;
  logic rx_toggle;
  amc_op_type cmd_op;
  logic [3:0] mode_in;
  logic [1:0] stream_in;
  logic [3:0] mode_now;
  logic in_cread;
  logic [15:0] write_value;
  logic refuse;
  logic rdy_fall;
  logic tog_event;
  logic [31:0] slot_one;

  function automatic logic tx_bit(input amc_host_state_type v);
    if (v.op == OP_IFRESET) begin
      return v.cnt[5:0] != RESET_ZERO_POS;
    end
    if (v.cnt >= REG_BITS) begin
      return 1'b0;
    end
    return v.tx[5'(TX_BITS - 1) - v.cnt[4:0]];
  endfunction : tx_bit

  // ==========================================================
  // Stream receiver on the device's data clock
  amc_stream_rx u_rx (
    .bit_clk(STREAM_BIT_CLOCK),
    .reset(RESET),
    .sdo(MISO),
    .frame_sync(AUX_PIN_ONE),
    .two_slots(STREAM_TWO_SLOTS),
    .word(rx_word),
    .word_toggle(rx_toggle)
  );

  // ==========================================================
  // Command checks
  assign cmd_op = amc_op_type'(CMD_OP);
  assign mode_in = CMD_WDATA[CTRL_MODE_LSB +: 4];
  assign stream_in = CMD_WDATA[CTRL_STREAM_LSB +: 2];
  assign mode_now = state_reg.ctrl[CTRL_MODE_LSB +: 4];
  assign in_cread =
    state_reg.ctrl[CTRL_STREAM_LSB +: 2] == STREAM_READ;

  // Reserved bits are cleared before they reach the wire.
  always_comb begin
    write_value = CMD_WDATA;
    if (CMD_ADDR == OFS_CTRL) begin
      write_value = CMD_WDATA & MASK_CTRL;
    end else if (CMD_ADDR == OFS_SWITCH) begin
      write_value = CMD_WDATA & MASK_SWITCH;
    end else if (CMD_ADDR == OFS_STANDBY) begin
      write_value = CMD_WDATA & MASK_STANDBY;
      if (CMD_WDATA[STBY_EXC_BIT] || CMD_WDATA[STBY_DAC_BIT]) begin
        write_value[STBY_REF_BIT] = 1'b1;
      end
    end
  end

  always_comb begin
    refuse = 1'b0;
    if (CMD_OP > OP_IFRESET) begin
      refuse = 1'b1;
    end else if (mode_now == MODE_PWRDN && cmd_op != OP_IFRESET) begin
      refuse = 1'b1;
    end else if (cmd_op == OP_WRITE || cmd_op == OP_READ) begin
      refuse = in_cread;
      if (cmd_op == OP_WRITE && CMD_ADDR == OFS_CTRL) begin
        if (stream_in == 2'h3) begin
          refuse = 1'b1;
        end
        if (stream_in != STREAM_OFF && mode_in != MODE_CONT &&
            mode_in != MODE_FIR) begin
          refuse = 1'b1;
        end
        if (mode_in == MODE_PWRDN && mode_now != MODE_STANDBY) begin
          refuse = 1'b1;
        end
      end
    end else if (cmd_op == OP_FETCH || cmd_op == OP_EXIT) begin
      refuse = !in_cread;
    end
  end

  // Ready low only counts once two synchroniser stages agree.
  assign rdy_fall = state_reg.rdy_lvl &&
    state_reg.rdy_s[1] == state_reg.rdy_s[2] && !state_reg.rdy_s[2];
  assign tog_event = state_reg.tog_s[1] ^ state_reg.tog_s[2];
  assign slot_one = STREAM_TWO_SLOTS ? rx_word[63:32] : rx_word[31:0];

  // ==========================================================
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.rsp_valid = 1'b0;
    state_next.err = 1'b0;
    state_next.str_valid = 1'b0;
    state_next.miso_s = {state_reg.miso_s[1:0], MISO};
    if (state_reg.miso_s[1] == state_reg.miso_s[2]) begin
      state_next.miso_lvl = state_reg.miso_s[2];
    end
    state_next.rdy_s = {state_reg.rdy_s[1:0], AUX_PIN_ONE};
    if (state_reg.rdy_s[1] == state_reg.rdy_s[2]) begin
      state_next.rdy_lvl = state_reg.rdy_s[2];
    end
    state_next.tog_s = {state_reg.tog_s[1:0], rx_toggle};
    if (tog_event &&
        state_reg.ctrl[CTRL_STREAM_LSB +: 2] == STREAM_XMIT) begin
      state_next.str_valid = 1'b1;
      if (state_reg.ctrl[CTRL_STATUS_BIT]) begin
        state_next.str_stat = slot_one[31:24];
        state_next.str_data = slot_one[23:0];
      end else begin
        state_next.str_stat = 8'h00;
        state_next.str_data = slot_one[31:8];
      end
      state_next.str_check = STREAM_TWO_SLOTS ? rx_word[31:0]
                                              : 32'h0000_0000;
    end
    case (state_reg.st)
      ST_IDLE: begin
        if (CMD_VALID && refuse) begin
          state_next.err = 1'b1;
        end else if (CMD_VALID) begin
          state_next.op = cmd_op;
          state_next.cnt = 8'h00;
          state_next.ph = 3'h0;
          state_next.rx = 32'h0000_0000;
          state_next.tx = 24'h00_0000;
          state_next.nbits = REG_BITS;
          case (cmd_op)
            OP_WRITE: begin
              state_next.tx = {1'b0, CMD_ADDR[6:0], write_value};
            end
            OP_READ: begin
              state_next.tx = {1'b1, CMD_ADDR[6:0], 16'h0000};
            end
            OP_FETCH: begin
              state_next.nbits = state_reg.ctrl[CTRL_STATUS_BIT]
                ? FETCH_STATUS_BITS : FETCH_BITS;
            end
            OP_EXIT: begin
              state_next.tx = {EXIT_BYTE, 16'h0000};
              state_next.nbits = EXIT_BITS;
            end
            default: begin
              state_next.nbits = RESET_BITS;
            end
          endcase
          if (cmd_op == OP_FETCH || cmd_op == OP_EXIT) begin
            state_next.st = ST_WAIT;
          end else begin
            state_next.st = ST_LOW;
            state_next.csn = 1'b0;
            state_next.sclk = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        // Fetch and exit go out only right after ready falls.
        if (rdy_fall) begin
          state_next.st = ST_LOW;
          state_next.csn = 1'b0;
          state_next.sclk = 1'b0;
        end
      end
      ST_LOW: begin
        state_next.ph = state_reg.ph + 3'h1;
        if (state_reg.ph == SPI_HALF_LAST) begin
          state_next.st = ST_HIGH;
          state_next.sclk = 1'b1;
          state_next.ph = 3'h0;
        end
      end
      ST_HIGH: begin
        state_next.ph = state_reg.ph + 3'h1;
        if (state_reg.ph == SPI_HALF_LAST) begin
          state_next.ph = 3'h0;
          state_next.rx = {state_reg.rx[30:0], state_reg.miso_lvl};
          state_next.cnt = state_reg.cnt + 8'h01;
          if (state_reg.cnt + 8'h01 == state_reg.nbits) begin
            state_next.st = ST_DONE;
            state_next.csn = 1'b1;
          end else begin
            state_next.st = ST_LOW;
            state_next.sclk = 1'b0;
          end
        end
      end
      ST_DONE: begin
        state_next.st = ST_IDLE;
        state_next.rsp_valid = 1'b1;
        state_next.rsp_data = state_reg.rx;
        if (state_reg.op == OP_WRITE) begin
          case (state_reg.tx[22:16])
            OFS_CTRL[6:0]: state_next.ctrl = state_reg.tx[15:0];
            OFS_STANDBY[6:0]: state_next.stby = state_reg.tx[15:0];
            OFS_SWITCH[6:0]: state_next.lsw = state_reg.tx[15:0];
            default: begin
            end
          endcase
        end else if (state_reg.op == OP_EXIT) begin
          state_next.ctrl[CTRL_STREAM_LSB +: 2] = STREAM_OFF;
        end else if (state_reg.op == OP_IFRESET) begin
          state_next.ctrl[CTRL_STREAM_LSB +: 2] = STREAM_OFF;
          if (mode_now == MODE_PWRDN) begin
            state_next.ctrl = RST_CTRL;
            state_next.stby = RST_STANDBY;
            state_next.lsw = RST_SWITCH;
          end
        end
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase
    if (state_next.st == ST_LOW && state_reg.st != ST_LOW) begin
      state_next.mosi = tx_bit(state_next);
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= '0;
      state_reg.csn <= 1'b1;
      state_reg.sclk <= 1'b1;
      state_reg.rdy_lvl <= 1'b1;
      state_reg.rdy_s <= 3'h7;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign CMD_READY = state_reg.st == ST_IDLE;
  assign CMD_ERROR = state_reg.err;
  assign RSP_VALID = state_reg.rsp_valid;
  assign RSP_DATA = state_reg.rsp_data;
  assign SCLK = state_reg.sclk;
  assign CS_N = state_reg.csn;
  assign MOSI = state_reg.mosi;
  assign STREAM_VALID = state_reg.str_valid;
  assign STREAM_DATA = state_reg.str_data;
  assign STREAM_STATUS = state_reg.str_stat;
  assign STREAM_CHECK = state_reg.str_check;
  assign CTRL_SHADOW = state_reg.ctrl;
  assign STANDBY_SHADOW = state_reg.stby;
  assign SWITCH_SHADOW = state_reg.lsw;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  a_cs_frame: assert property (
    (state_reg.st == ST_LOW || state_reg.st == ST_HIGH) |-> !CS_N)
    else $error("Chip select released inside a transfer.");

  a_sclk_half: assert property (
    (state_reg.st == ST_LOW && $past(state_reg.st) != ST_LOW)
    |-> (!SCLK)[*5] ##1 SCLK)
    else $error("Serial clock low phase has the wrong length.");

  a_exit_after_ready: assert property (
    (state_reg.st == ST_LOW && $past(state_reg.st) == ST_WAIT)
    |-> $past(rdy_fall))
    else $error("Transfer started without a ready fall.");

  a_exit_length: assert property (
    (state_reg.st == ST_DONE && state_reg.op == OP_EXIT)
    |-> state_reg.cnt == 8'h08 && state_reg.tx[23:16] == 8'hA5)
    else $error("Exit transfer is not one exit byte.");

  a_reset_length: assert property (
    (state_reg.st == ST_DONE && state_reg.op == OP_IFRESET)
    |-> state_reg.cnt == 8'hC0)
    else $error("Interface reset pattern has the wrong length.");

  a_reset_zero: assert property (
    (state_reg.st == ST_HIGH && state_reg.op == OP_IFRESET)
    |-> MOSI == (state_reg.cnt[5:0] != 6'h3F))
    else $error("Interface reset pattern bit is wrong.");

  a_standby_ref: assert property (
    (state_reg.stby[1] || state_reg.stby[5]) |-> state_reg.stby[0])
    else $error("Reference not kept with its dependants.");

  a_reserved_zero: assert property (
    state_reg.ctrl[15:8] == 8'h00 && state_reg.lsw[15:2] == 14'h0000
    && state_reg.stby[15:9] == 7'h00 && !state_reg.stby[6])
    else $error("Reserved bit written as one.");

  a_stream_mode: assert property (
    state_reg.ctrl[5:4] != 2'h0 |-> state_reg.ctrl[3:1] == 3'h0)
    else $error("Streaming selected outside a continuous mode.");

  a_powerdown_entry: assert property (
    ($changed(state_reg.ctrl[3:0]) && state_reg.ctrl[3:0] == 4'h6)
    |-> $past(state_reg.ctrl[3:0]) == 4'h5)
    else $error("Power-down entered from a mode other than standby.");

endmodule : amc_host_ctrl

// ===== common/amc_pkg.sv
// Constants and types shared by the converter mode controller.
package amc_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SPI_HALF_NS = 40;
  localparam int SPI_HALF_CYCLES =
    (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SPI_HALF_LAST = 3'(SPI_HALF_CYCLES - 1);

  // ==========================================================
  // Register map of the device
  localparam logic [7:0] OFS_STANDBY = 8'h6C;
  localparam logic [7:0] OFS_SWITCH = 8'h6E;
  localparam logic [7:0] OFS_CTRL = 8'h70;
  localparam logic [15:0] RST_STANDBY = 16'h0000;
  localparam logic [15:0] RST_SWITCH = 16'h0000;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] MASK_STANDBY = 16'h01BF;
  localparam logic [15:0] MASK_SWITCH = 16'h0003;
  localparam logic [15:0] MASK_CTRL = 16'h00FF;

  // ==========================================================
  // Field positions
  localparam int CTRL_MULTI_REG_BIT = 7;
  localparam int CTRL_STATUS_BIT = 6;
  localparam int CTRL_STREAM_LSB = 4;
  localparam int CTRL_MODE_LSB = 0;
  localparam int STBY_PULLUP_BIT = 7;
  localparam int STBY_DAC_BIT = 5;
  localparam int STBY_SW1_BIT = 4;
  localparam int STBY_SW0_BIT = 3;
  localparam int STBY_BIAS_BIT = 2;
  localparam int STBY_EXC_BIT = 1;
  localparam int STBY_REF_BIT = 0;
  localparam int SW_ONE_BIT = 1;
  localparam int SW_ZERO_BIT = 0;
  localparam int INSTR_READ_BIT = 7;

  // ==========================================================
  // Field encodings
  localparam logic [1:0] STREAM_OFF = 2'h0;
  localparam logic [1:0] STREAM_READ = 2'h1;
  localparam logic [1:0] STREAM_XMIT = 2'h2;
  localparam logic [3:0] MODE_CONT = 4'h0;
  localparam logic [3:0] MODE_FIR = 4'h1;
  localparam logic [3:0] MODE_SINGLE = 4'h4;
  localparam logic [3:0] MODE_STANDBY = 4'h5;
  localparam logic [3:0] MODE_PWRDN = 4'h6;
  localparam logic [3:0] MODE_IDLE = 4'h7;
  localparam logic [3:0] MODE_CAL_SYS_OFS = 4'h8;
  localparam logic [3:0] MODE_CAL_SYS_GAIN = 4'h9;
  localparam logic [3:0] MODE_CAL_INT_OFS = 4'hA;

  // ==========================================================
  // Serial framing
  localparam logic [7:0] EXIT_BYTE = 8'hA5;
  localparam int RESET_ONES = 63;
  localparam int RESET_REPEATS = 3;
  localparam logic [5:0] RESET_ZERO_POS = 6'(RESET_ONES);
  localparam logic [7:0] RESET_BITS =
    8'((RESET_ONES + 1) * RESET_REPEATS);
  localparam int TX_BITS = 24;
  localparam logic [7:0] REG_BITS = 8'(TX_BITS);
  localparam logic [7:0] EXIT_BITS = 8'h08;
  localparam logic [7:0] FETCH_BITS = 8'h18;
  localparam logic [7:0] FETCH_STATUS_BITS = 8'h20;
  localparam int SLOT_BITS = 32;

  typedef enum logic [2:0] {
    OP_WRITE = 3'h0,
    OP_READ = 3'h1,
    OP_FETCH = 3'h2,
    OP_EXIT = 3'h3,
    OP_IFRESET = 3'h4
  } amc_op_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_LOW = 3'h3,
    ST_HIGH = 3'h2,
    ST_DONE = 3'h6
  } amc_state_type;

endpackage : amc_pkg

// ===== core/amc_stream_rx.sv
// Receiver for streamed frames on the device's data clock.
`timescale 1ns/1ps
module amc_stream_rx import amc_pkg::*; (
  input wire logic bit_clk,
  input wire logic reset,
  input wire logic sdo,
  input wire logic frame_sync,
  input wire logic two_slots,
  output logic [63:0] word,
  output logic word_toggle
);

  typedef struct packed {
    logic [1:0] two_s;
    logic active;
    logic [6:0] cnt;
    logic [63:0] sh;
    logic [63:0] word;
    logic tog;
  } amc_rx_state_type;

  amc_rx_state_type rx_reg;
  amc_rx_state_type rx_next;
  logic [6:0] last_bit;
  logic [63:0] shifted;

  assign last_bit = rx_reg.two_s[1] ? 7'(2 * SLOT_BITS - 1)
                                    : 7'(SLOT_BITS - 1);
  assign shifted = {rx_reg.sh[62:0], sdo};

  // ==========================================================
  // Frame capture
  // The frame sync marks the first bit; one or two slots follow.
  always_comb begin
    rx_next = rx_reg;
    rx_next.two_s = {rx_reg.two_s[0], two_slots};
    if (!rx_reg.active) begin
      if (frame_sync) begin
        rx_next.active = 1'b1;
        rx_next.sh = shifted;
        rx_next.cnt = 7'h01;
      end
    end else begin
      rx_next.sh = shifted;
      if (rx_reg.cnt == last_bit) begin
        rx_next.word = shifted;
        rx_next.tog = ~rx_reg.tog;
        rx_next.active = 1'b0;
      end else begin
        rx_next.cnt = rx_reg.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge bit_clk or posedge reset) begin
    if (reset) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  assign word = rx_reg.word;
  assign word_toggle = rx_reg.tog;

  a_frame_size: assert property (
    @(posedge bit_clk) disable iff (reset)
    !(rx_reg.active && rx_reg.cnt == last_bit) |=> $stable(rx_reg.tog))
    else $error("Frame word released at the wrong bit count.");

  a_frame_release: assert property (
    @(posedge bit_clk) disable iff (reset)
    rx_reg.active && rx_reg.cnt == last_bit |=> $changed(rx_reg.tog))
    else $error("Frame word not released at its last bit.");

endmodule : amc_stream_rx

// ===== tb/amc_dev_model.sv
// Behavioural model of the converter's serial port and stream output.
`timescale 1ns/1ps
module amc_dev_model import amc_pkg::*; (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic aux_one,
  output logic bit_clk
);
  logic [15:0] stby = 16'h0, sw = 16'h0, ctrl = 16'h0, rdv = 16'h0;
  logic [31:0] res = 32'h0;
  logic [23:0] sr = 24'h0;
  logic [7:0] keep;
  logic [1:0] act;
  int cnt = 0, ones = 0, reps = 0, seq_resets = 0;

  initial begin
    miso = 1'b0;
    aux_one = 1'b1;
    bit_clk = 1'b0;
  end

  // ==========================================================
  // Power state
  assign keep = (ctrl[3:0] == MODE_STANDBY) ? stby[7:0] : 8'hFF;
  always_comb begin
    case (ctrl[3:0])
      MODE_CONT, MODE_FIR: act = 2'h3;
      MODE_SINGLE: act = 2'h2;
      MODE_STANDBY: act = 2'h1;
      MODE_IDLE, MODE_CAL_SYS_OFS, MODE_CAL_SYS_GAIN,
      MODE_CAL_INT_OFS: act = 2'h2;
      default: act = 2'h0;
    endcase
  end

  // ==========================================================
  // Serial port
  function automatic logic [15:0] rd_reg(input logic [6:0] a);
    case ({1'b0, a})
      OFS_STANDBY: return stby;
      OFS_SWITCH: return sw;
      OFS_CTRL: return ctrl;
      default: return 16'h0;
    endcase
  endfunction : rd_reg

  always @(negedge cs_n) cnt = 0;

  always @(posedge sclk) if (!cs_n) begin
    sr = {sr[22:0], mosi};
    cnt++;
    if (cnt == 8) rdv = rd_reg(sr[6:0]);
    if (mosi) ones++;
    else begin
      reps = (ones == RESET_ONES) ? reps + 1 : 0;
      ones = 0;
    end
    if (reps == RESET_REPEATS) begin
      reps = 0;
      ctrl[5:4] = STREAM_OFF;
      if (ctrl[3:0] == MODE_PWRDN) {stby, sw, ctrl} = '0;
    end
  end

  always @(negedge sclk) begin
    #1;
    if (!cs_n) begin
      if (ctrl[5:4] == STREAM_READ && cnt < 32) miso = res[31 - cnt];
      else if (cnt >= 8 && cnt < 24) miso = rdv[23 - cnt];
      else miso = ~miso;
    end
  end

  always @(posedge cs_n) begin
    if (ctrl[5:4] == STREAM_READ) begin
      if (cnt == 8 && sr[7:0] == EXIT_BYTE) ctrl[5:4] = STREAM_OFF;
    end else if (cnt == 24 && !sr[23]) begin
      case ({1'b0, sr[22:16]})
        OFS_STANDBY: stby = sr[15:0] & MASK_STANDBY;
        OFS_SWITCH: sw = sr[15:0] & MASK_SWITCH;
        OFS_CTRL: begin
          ctrl = sr[15:0] & MASK_CTRL;
          seq_resets++;
        end
        default: ;
      endcase
    end
    aux_one = 1'b1;
    #1 miso = ~miso;
  end

  // ==========================================================
  // Results
  task automatic post_result(input logic [23:0] d, input logic [7:0] st);
    res = {d, st};
    aux_one = 1'b0;
  endtask : post_result

  // Sends even when streaming is off only if any is set.
  task automatic send_frame(input logic [23:0] d, input logic [7:0] st,
      input logic [31:0] chk, input logic two, input logic any);
    logic [63:0] w;
    int nb;
    w = {ctrl[6] ? {st, d} : {d, 8'h00}, chk};
    nb = two ? 64 : 32;
    if (ctrl[5:4] == STREAM_XMIT || any) for (int i = 0; i < nb; i++) begin
      miso = w[63 - i];
      aux_one = (i == 0);
      #15 bit_clk = 1'b1;
      #15 bit_clk = 1'b0;
    end
    aux_one = 1'b1;
    miso = ~miso;
  endtask : send_frame
endmodule : amc_dev_model

// ===== tb/tb.sv
// Self-checking bench for the converter mode controller.
`timescale 1ns/1ps
module tb import amc_pkg::*;;
  typedef struct {
    logic [65:0] val;
    logic [65:0] mask;
  } amc_note_type;

  logic CLK = 1'b0, RESET = 1'b0, CMD_VALID = 1'b0, STREAM_TWO_SLOTS = 1'b0;
  logic [2:0] CMD_OP = 3'h0;
  logic [7:0] CMD_ADDR = 8'h0;
  logic [15:0] CMD_WDATA = 16'h0;
  logic MISO, AUX_PIN_ONE, STREAM_BIT_CLOCK, CMD_READY, CMD_ERROR;
  logic RSP_VALID, SCLK, CS_N, MOSI, STREAM_VALID;
  logic [31:0] RSP_DATA, STREAM_CHECK, r, c;
  logic [23:0] STREAM_DATA;
  logic [7:0] STREAM_STATUS;
  logic [15:0] CTRL_SHADOW, STANDBY_SHADOW, SWITCH_SHADOW, d, e, sh;
  logic [65:0] got;
  amc_note_type n;
  amc_note_type notes[$];
  int n_errors = 0, checked = 0;
  logic [7:0] ofs [3] = '{OFS_STANDBY, OFS_SWITCH, OFS_CTRL};
  logic [15:0] msk [3] = '{MASK_STANDBY, MASK_SWITCH, MASK_CTRL};
  logic [2:0] rop [8] = '{3'h5, 3'h6, 3'h7, OP_WRITE, OP_WRITE, OP_WRITE,
    OP_FETCH, OP_EXIT};
  logic [15:0] rdat [8] = '{16'h0, 16'h0, 16'h0, 16'h0030, 16'h0014,
    16'h0006, 16'h0, 16'h0};

  always #4 CLK = ~CLK;

  amc_host_ctrl i_dut (.CLK(CLK), .RESET(RESET), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR),
    .CMD_WDATA(CMD_WDATA), .CMD_ERROR(CMD_ERROR), .RSP_VALID(RSP_VALID),
    .RSP_DATA(RSP_DATA), .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO),
    .AUX_PIN_ONE(AUX_PIN_ONE), .STREAM_BIT_CLOCK(STREAM_BIT_CLOCK),
    .STREAM_TWO_SLOTS(STREAM_TWO_SLOTS), .STREAM_VALID(STREAM_VALID),
    .STREAM_DATA(STREAM_DATA), .STREAM_STATUS(STREAM_STATUS),
    .STREAM_CHECK(STREAM_CHECK), .CTRL_SHADOW(CTRL_SHADOW),
    .STANDBY_SHADOW(STANDBY_SHADOW), .SWITCH_SHADOW(SWITCH_SHADOW));

  amc_dev_model i_dev (.sclk(SCLK), .cs_n(CS_N), .mosi(MOSI), .miso(MISO),
    .aux_one(AUX_PIN_ONE), .bit_clk(STREAM_BIT_CLOCK));

  // ==========================================================
  // Checking
  task automatic check(input logic [65:0] g, input logic [65:0] x);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : check

  task automatic note(input logic [1:0] k, input logic [63:0] v,
      input logic [63:0] m);
    notes.push_back('{{k, v & m}, {2'h3, m}});
  endtask : note

  // Kind 0 is a finish, 1 a refusal, 2 a streamed frame.
  always @(negedge CLK) begin
    if (RSP_VALID === 1'b1 || CMD_ERROR === 1'b1 ||
        STREAM_VALID === 1'b1) begin
      got = STREAM_VALID === 1'b1 ?
        {2'h2, STREAM_CHECK, STREAM_STATUS, STREAM_DATA} :
        CMD_ERROR === 1'b1 ? {2'h1, 64'h0} : {2'h0, 32'h0, RSP_DATA};
      if (notes.size() == 0) check(got, {2'h3, 64'h0});
      else begin
        n = notes.pop_front();
        check(got & n.mask, n.val);
      end
    end
  end

  // ==========================================================
  // Commands
  task automatic go(input logic [2:0] op, input logic [7:0] a,
      input logic [15:0] wd, input logic [1:0] k, input logic [31:0] v,
      input logic [31:0] m);
    int w;
    note(k, {32'h0, v}, {32'h0, m});
    @(negedge CLK);
    CMD_VALID = 1'b1;
    CMD_OP = op;
    CMD_ADDR = a;
    CMD_WDATA = wd;
    w = 0;
    do begin
      @(posedge CLK);
      w++;
    end while (CMD_READY !== 1'b1 && w < 5000);
    @(negedge CLK);
    CMD_VALID = 1'b0;
    while (CMD_READY !== 1'b1 && w < 5000) begin
      @(negedge CLK);
      w++;
    end
    if (w >= 5000) begin
      n_errors++;
      $display("Error at %0t: command never finished", $time);
    end
    repeat (2) @(negedge CLK);
  endtask : go

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // Cuts a hang short well beyond the expected run of about 9300 cycles.
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end

  // ==========================================================
  // Scenarios
  initial begin
    r = $urandom(14);
    #1 RESET = 1'b1;
    repeat (4) @(posedge CLK);
    @(negedge CLK);
    RESET = 1'b0;
    for (int i = 0; i < 3; i++) go(OP_READ, ofs[i], 16'h0, 2'h0, 32'h0,
      32'hFFFF);
    for (int i = 0; i < 3; i++) begin
      d = 16'($urandom);
      if (i == 0) d = (d & 16'hFFFE) | 16'h0002;
      if (i == 2) d = (d & 16'hFFC0) | 16'(MODE_IDLE);
      e = (d & msk[i]) | ((i == 0) ? 16'h0001 : 16'h0);
      go(OP_WRITE, ofs[i], d, 2'h0, 32'h0, 32'h0);
      sh = (i == 0) ? STANDBY_SHADOW : (i == 1) ? SWITCH_SHADOW : CTRL_SHADOW;
      check({50'h0, sh & msk[i]}, {50'h0, e});
      go(OP_READ, ofs[i], 16'h0, 2'h0, {16'h0, e}, 32'hFFFF);
    end
    for (int i = 0; i < 8; i++) go(rop[i], OFS_CTRL, rdat[i], 2'h1, 32'h0,
      32'h0);
    for (int i = 0; i < 2; i++) begin
      d = i ? 16'h0051 : 16'h0010;
      go(OP_WRITE, OFS_CTRL, d, 2'h0, 32'h0, 32'h0);
      r = $urandom;
      i_dev.post_result(r[23:0], r[31:24]);
      go(OP_FETCH, 8'h0, 16'h0, 2'h0, i ? {r[23:0], r[31:24]} : r,
        i ? 32'hFFFFFFFF : 32'hFFFFFF);
      go(OP_WRITE, OFS_SWITCH, 16'h3, 2'h1, 32'h0, 32'h0);
      go(OP_READ, OFS_CTRL, 16'h0, 2'h1, 32'h0, 32'h0);
      i_dev.post_result(24'h0, 8'h0);
      go(OP_EXIT, 8'h0, 16'h0, 2'h0, 32'h0, 32'h0);
      go(OP_READ, OFS_CTRL, 16'h0, 2'h0, {16'h0, d & 16'hFFCF},
        32'hFFFF);
    end
    for (int i = 0; i < 4; i++) begin
      STREAM_TWO_SLOTS = i[1];
      go(OP_WRITE, OFS_CTRL, i[0] ? 16'h0060 : 16'h0020, 2'h0, 32'h0,
        32'h0);
      r = $urandom;
      c = $urandom;
      note(2'h2, {c, i[0] ? r[31:24] : 8'h00, r[23:0]},
        {i[1] ? 32'hFFFFFFFF : 32'h0, 32'hFFFFFFFF});
      #3 i_dev.send_frame(r[23:0], r[31:24], c, i[1], 1'b0);
      repeat (20) @(negedge CLK);
    end
    STREAM_TWO_SLOTS = 1'b0;
    go(OP_WRITE, OFS_CTRL, 16'h0, 2'h0, 32'h0, 32'h0);
    #3 i_dev.send_frame(24'h5A5A5A, 8'hC3, 32'h0, 1'b0, 1'b1);
    repeat (20) @(negedge CLK);
    go(OP_WRITE, OFS_CTRL, 16'h0005, 2'h0, 32'h0, 32'h0);
    go(OP_WRITE, OFS_CTRL, 16'h0006, 2'h0, 32'h0, 32'h0);
    go(OP_READ, OFS_SWITCH, 16'h0, 2'h1, 32'h0, 32'h0);
    go(OP_IFRESET, 8'h0, 16'h0, 2'h0, 32'h0, 32'h0);
    for (int i = 0; i < 3; i++) go(OP_READ, ofs[i], 16'h0, 2'h0, 32'h0,
      32'hFFFF);
    repeat (10) @(negedge CLK);
    check(66'(notes.size()), 66'h0);
    print_verdict();
  end
endmodule : tb
